/* File: hdl/cfe_cfg.svh */
// Build-time limits, defaults and reset values of the convolutional encoder
`ifndef CFE_CFG_SVH
`define CFE_CFG_SVH

// Fewest and most generator codes the encoder serves
`define CFE_MIN_CODES 2
`define CFE_MAX_CODES 7
// Shortest and longest constraint length the encoder serves
`define CFE_MIN_K 2
`define CFE_MAX_K 16
// Default constraint length and default octal generator pair
`define CFE_DEF_K 7
`define CFE_DEF_NUM_CODES 2
`define CFE_DEF_CODE0 16'o171
`define CFE_DEF_CODE1 16'o133
// Reset value of every shift stage; the output flops reset to a fixed zero
`define CFE_STAGE_RST 1'b0
// Clock-to-output latency of coded bits after an accepted bit
`define CFE_LATENCY 1

`endif

/* File: hdl/cfe_encoder.sv */
// Feed-forward convolutional encoder, top level
`timescale 1ns/1ps
`include "cfe_cfg.svh"

module cfe_encoder #(
    parameter int CONSTRAINT_LEN = `CFE_DEF_K,
    parameter int NUM_CODES = `CFE_DEF_NUM_CODES,
    // Entry 0 is the first code; only the low CONSTRAINT_LEN bits are used
    parameter logic [`CFE_MAX_CODES-1:0][`CFE_MAX_K-1:0] GEN_CODES =
        {80'h0, `CFE_DEF_CODE1, `CFE_DEF_CODE0},
    parameter bit USE_ENABLE = 1'b0
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Encoder control
    input wire logic encoder_clear,
    input wire logic encoder_enable,
    // Bit source
    input wire logic data_in,
    input wire logic data_in_valid,
    // Coded stream to the decoder
    output logic [NUM_CODES-1:0] coded_bits,
    output logic coded_bit_first,
    output logic coded_bit_second,
    output logic coded_valid
);

    localparam int DEPTH = CONSTRAINT_LEN - 1;

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    if (NUM_CODES < `CFE_MIN_CODES || NUM_CODES > `CFE_MAX_CODES) begin : g_bad_n
        $error("cfe_encoder: NUM_CODES must lie in 2..7");
    end
    if (CONSTRAINT_LEN < `CFE_MIN_K || CONSTRAINT_LEN > `CFE_MAX_K) begin : g_bad_k
        $error("cfe_encoder: CONSTRAINT_LEN out of range");
    end
    for (genvar c = 0; c < NUM_CODES; c++) begin : g_chk
        if ((GEN_CODES[c] >> CONSTRAINT_LEN) != 0) begin : g_bad_code
            $error("cfe_encoder: generator code wider than window");
        end
        if (GEN_CODES[c] == 0) begin : g_zero_code
            $error("cfe_encoder: generator code is zero");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Acceptance

    cfe_pkg::cfe_sample_t sample;
    cfe_pkg::cfe_ctrl_t ctrl;
    logic enable_eff;
    logic accept;

    // Without an enable port the encoder always runs
    assign enable_eff = USE_ENABLE ? encoder_enable : 1'b1;
    // A single unsigned bit per symbol is all the datapath carries
    assign sample = '{bit_in: data_in, valid: data_in_valid};
    // Clear wins over a bit offered in the same cycle
    assign accept = sample.valid && enable_eff && !encoder_clear;
    assign ctrl = '{clear: encoder_clear, shift: accept};

    ////////////////////////////////////////////////////////////////////////
    // Shift register and window

    logic [DEPTH-1:0] stages;
    logic [DEPTH-1:0] stages_rev;
    logic [CONSTRAINT_LEN-1:0] window;

    cfe_shift_reg #(
        .DEPTH(DEPTH)
    ) u_shift (
        .clock(clock),
        .resetn(resetn),
        .ctrl(ctrl),
        .bit_in(sample.bit_in),
        .stages(stages)
    );

    // Stage 0 holds the newest stored bit, so it must sit just below the
    // input; a plain concatenation would hand the oldest bit to code bit K-2
    for (genvar s = 0; s < DEPTH; s++) begin : g_rev
        assign stages_rev[DEPTH-1-s] = stages[s];
    end

    // Newest bit sits at the top so the code MSB reaches it
    assign window = {sample.bit_in, stages_rev};

    ////////////////////////////////////////////////////////////////////////
    // Parity per generator

    logic [NUM_CODES-1:0] parity;

    for (genvar c = 0; c < NUM_CODES; c++) begin : g_code
        cfe_tap_sum #(
            .WIDTH(CONSTRAINT_LEN),
            .TAPS(GEN_CODES[c][CONSTRAINT_LEN-1:0])
        ) u_sum (
            .window(window),
            .parity(parity[c])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Output registers

    logic [NUM_CODES-1:0] coded_q;
    logic [NUM_CODES-1:0] coded_d;
    logic valid_q;
    logic valid_d;

    // Coded bits hold their last value between accepted inputs
    assign coded_d = accept ? parity : coded_q;
    assign valid_d = accept;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            coded_q <= '0;
            valid_q <= 1'b0;
        end else begin
            coded_q <= coded_d;
            valid_q <= valid_d;
        end
    end

    assign coded_bits = coded_q;
    assign coded_bit_first = coded_q[0];
    assign coded_bit_second = coded_q[1];
    assign coded_valid = valid_q;

endmodule : cfe_encoder

/* File: hdl/cfe_pkg.sv */
// Types shared by the convolutional encoder modules
package cfe_pkg;

    // One input sample as offered by the bit source
    typedef struct packed {
        logic bit_in;
        logic valid;
    } cfe_sample_t;

    // Control applied to the shift register in one cycle
    typedef struct packed {
        logic clear;
        logic shift;
    } cfe_ctrl_t;

endpackage : cfe_pkg

/* File: hdl/cfe_shift_reg.sv */
// Feed-forward delay line holding the previously accepted input bits
`timescale 1ns/1ps
`include "cfe_cfg.svh"

module cfe_shift_reg #(
    parameter int DEPTH = `CFE_DEF_K - 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Control and data
    input wire cfe_pkg::cfe_ctrl_t ctrl,
    input wire logic bit_in,
    // Stages, index 0 newest
    output logic [DEPTH-1:0] stages
);

    logic [DEPTH-1:0] stages_q;
    logic [DEPTH-1:0] stages_d;
    logic [DEPTH-1:0] shifted;

    if (DEPTH < 1) begin : g_bad_depth
        $error("cfe_shift_reg: DEPTH must be at least 1");
    end

    if (DEPTH > 1) begin : g_wide
        assign shifted = {stages_q[DEPTH-2:0], bit_in};
    end else begin : g_one
        assign shifted = bit_in;
    end

    // Clear outranks shift; otherwise the line holds its contents
    assign stages_d = ctrl.clear ? {DEPTH{`CFE_STAGE_RST}} :
                      ctrl.shift ? shifted : stages_q;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            stages_q <= {DEPTH{`CFE_STAGE_RST}};
        end else begin
            stages_q <= stages_d;
        end
    end

    assign stages = stages_q;

endmodule : cfe_shift_reg

/* File: hdl/cfe_tap_sum.sv */
// Modulo-two sum of the data window under one constant tap mask
`timescale 1ns/1ps

module cfe_tap_sum #(
    parameter int WIDTH = 7,
    parameter logic [WIDTH-1:0] TAPS = '1
) (
    // Window, bit WIDTH-1 newest
    input wire logic [WIDTH-1:0] window,
    // Parity of the selected taps
    output logic parity
);

    if (WIDTH < 1) begin : g_bad_width
        $error("cfe_tap_sum: WIDTH must be at least 1");
    end

    // A constant mask lets synthesis drop every zero tap outright
    assign parity = ^(window & TAPS);

endmodule : cfe_tap_sum

/* File: test/cfe_bit_src.sv */
// Upstream bit source model for the convolutional encoder
`timescale 1ns/1ps

module cfe_bit_src (
    // Clock
    input wire logic clock,
    // Requests from the bench
    input wire logic send,
    input wire logic bit_val,
    // Serial stream
    output logic data_in,
    output logic data_in_valid
);
    initial data_in = 1'b0;
    initial data_in_valid = 1'b0;
    // Idle cycles flip the line so a stale bit never passes for fresh
    always @(posedge clock) begin
        data_in_valid <= send;
        data_in <= send ? bit_val : ~data_in;
    end
endmodule : cfe_bit_src

/* File: test/cfe_encoder_asserts.sv */
// Port checks of the convolutional encoder
`timescale 1ns/1ps

module cfe_encoder_asserts #(
    parameter int NUM_CODES = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Control and source
    input wire logic encoder_clear,
    input wire logic encoder_enable,
    input wire logic data_in,
    input wire logic data_in_valid,
    // Coded stream
    input wire logic [NUM_CODES-1:0] coded_bits,
    input wire logic coded_bit_first,
    input wire logic coded_bit_second,
    input wire logic coded_valid
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    logic take;
    assign take = data_in_valid && !encoder_clear && encoder_enable;
    sequence clr_then(logic b);
        encoder_clear ##1 take && data_in == b;
    endsequence
    valid_after_take_a: assert property (take |=> coded_valid)
        else $error("coded_valid missing after taken bit");
    no_take_quiet_a: assert property (!take |=> !coded_valid)
        else $error("coded_valid without taken bit");
    bits_hold_a: assert property (!take |=> $stable(coded_bits))
        else $error("coded_bits moved without taken bit");
    first_port_a: assert property (coded_bit_first == coded_bits[0])
        else $error("coded_bit_first differs from code 0");
    second_port_a: assert property (coded_bit_second == coded_bits[1])
        else $error("coded_bit_second differs from code 1");
    clear_zero_a: assert property (clr_then(1'b0) |=> coded_bits == '0)
        else $error("zero after clear gave nonzero bits");
    // Holds only for codes whose top bit is set, as in the bench
    clear_one_a: assert property (clr_then(1'b1) |=> coded_bits == '1)
        else $error("one after clear missed a top tap");
    freeze_a: assert property (!encoder_enable |=> $stable(coded_bits))
        else $error("coded_bits moved while disabled");
endmodule : cfe_encoder_asserts

/* File: test/cfe_encoder_tb.sv */
// Self-checking bench for the convolutional encoder
`timescale 1ns/1ps

module cfe_encoder_tb;
    logic clock = 0, resetn = 0, encoder_clear = 0, encoder_enable = 1;
    logic send = 0, bit_val = 0, data_in, data_in_valid, first, second, cv;
    logic [2:0] coded_bits;
    logic [5:0] sh = '0;
    logic [2:0] exp_bits = '0;
    int n_mismatch = 0, check_count = 0, n_valid = 0, n_exp = 0;
    localparam logic [2:0][6:0] CODES = {7'h75, 7'h5B, 7'h79};
    always #10 clock = ~clock;
    always @(posedge clock) if (cv === 1'b1) n_valid++;
    cfe_bit_src u_cfe_bit_src (.clock(clock), .send(send), .bit_val(bit_val),
        .data_in(data_in), .data_in_valid(data_in_valid));
    cfe_encoder #(.NUM_CODES(3), .USE_ENABLE(1'b1),
        .GEN_CODES({64'h0, 16'h0075, 16'h005B, 16'h0079})) u_cfe_encoder (
        .clock(clock), .resetn(resetn), .encoder_clear(encoder_clear),
        .encoder_enable(encoder_enable), .data_in(data_in),
        .data_in_valid(data_in_valid), .coded_bits(coded_bits),
        .coded_bit_first(first), .coded_bit_second(second), .coded_valid(cv));
    task automatic chk(input string nm, input logic [7:0] e, g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // With clr set, the first bit is taken in the cycle right after a clear
    task automatic burst(input logic [15:0] pat, input int n, input bit acc,
        input bit clr);
        if (clr) sh = '0;
        for (int i = 0; i < n; i++) begin
            @(posedge clock) #1;
            encoder_clear = clr && i == 0;
            send = 1;
            bit_val = pat[i];
            for (int c = 0; c < 3 && acc; c++)
                exp_bits[c] = ^({pat[i], sh} & CODES[c]);
            if (acc) sh = {pat[i], sh[5:1]};
            n_exp += acc;
        end
        @(posedge clock) #1 send = 0;
        encoder_clear = 0;
        repeat (2) @(posedge clock);
        #1 chk("coded_bits", exp_bits, coded_bits);
        chk("valid count", n_exp, n_valid);
    endtask : burst
    task automatic t_stream;
        burst(16'hB4E1, 16, 1, 0);
        chk("first", exp_bits[0], first);
        chk("second", exp_bits[1], second);
    endtask : t_stream
    // Source keeps offering while disabled; nothing may be taken
    task automatic t_freeze;
        encoder_enable = 0;
        burst(16'h000F, 4, 0, 0);
        encoder_enable = 1;
    endtask : t_freeze
    task automatic t_clear;
        burst(16'h0001, 1, 1, 1);
        burst(16'h0002, 2, 1, 1);
        burst(16'h0002, 2, 1, 0);
    endtask : t_clear
    task automatic finish_test;
        if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test
    initial begin
        repeat (2) @(posedge clock);
        #1 resetn = 1;
        t_stream();
        t_freeze();
        t_clear();
        finish_test();
    end
    initial begin
        #100000;
        n_mismatch++;
        finish_test();
    end
endmodule : cfe_encoder_tb

bind cfe_encoder cfe_encoder_asserts #(.NUM_CODES(NUM_CODES)) u_chk (
    .clock(clock), .resetn(resetn), .encoder_clear(encoder_clear),
    .encoder_enable(encoder_enable), .data_in(data_in),
    .data_in_valid(data_in_valid), .coded_bits(coded_bits),
    .coded_bit_first(coded_bit_first), .coded_bit_second(coded_bit_second),
    .coded_valid(coded_valid));
